// *** logic/duart_status.sv ***
// Function
// - Channel B commands match A, no power-down
// - Software sends only non-conflicting commands together
// - Break takes one entry, blocks until marking
// - Break change flag on break start and end
// - Mid-character break needs next character low
// - Break bit cleared by error reset, rx reset
// - Framing error when first stop bit low
// - Parity error when parity checked and wrong
// - Multidrop puts address/data flag in parity bit
// - Overrun when full and shifter holds one
// - Overrun stays until error reset or rx reset command
// - Transmitter empty set on idle, enable, underrun
// - Transmitter empty cleared by load, disable, reset
// - Transmitter ready means queue not full
// - Ready clears on disable; loads while zero dropped
// - Full set on eighth entry, read clears unless waiting
// - Receiver ready set on entry, cleared when emptied
// - Channel B status mirrors channel A
// - Pins 7..4 latch or unmasked interrupt, open-drain
// - Pin 3 timer output open-drain
// - Pin 3 latch or channel B 1x clocks
// - Pin 2 latch or channel A clocks
// - Error reset clears break, parity, overrun
// - Break change reset command clears flag
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module duart_status
   import duart_status_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire rx_evt_t [1:0] rx_evt,
   input wire tx_evt_t [1:0] tx_evt,
   input wire logic [7:0] interrupt_status,
   input wire pin_src_t pin_src,
   output logic [1:0] tx_load,
   output logic [7:0] tx_data,
   output logic [1:0] rx_pop,
   output logic [1:0] tx_active,
   output logic [1:0] rx_active,
   output logic [1:0] break_change,
   output logic power_down,
   output logic [7:2] op_out,
   output logic [7:2] op_oe
);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   function automatic logic [7:0] chan_ofs(input logic c, input logic [7:0] o);
      chan_ofs = c ? 8'(o + CHAN_STRIDE) : o;
   endfunction : chan_ofs

   function automatic logic [7:0] status_byte(input chan_t s);
      status_byte = '0;
      status_byte[ST_BRK] = s.brk;
      status_byte[ST_FE] = s.fe;
      status_byte[ST_PE] = s.pe;
      status_byte[ST_OE] = s.oe;
      status_byte[ST_EMT] = s.emt;
      status_byte[ST_TRDY] = s.trdy;
      status_byte[ST_FULL] = s.full;
      status_byte[ST_RRDY] = s.rrdy;
   endfunction : status_byte

   chan_t [1:0] ch_q;
   chan_t [1:0] ch_d;
   logic [7:0] opsel_q;
   logic [7:0] latch_q;
   logic [3:0] mode_q;
   logic pd_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [1:0] tx_load_q;
   logic [7:0] tx_data_q;
   logic [1:0] rx_pop_q;
   logic [7:2] op_out_q;
   logic [7:2] op_oe_q;

   // Registered answer: no wait state, pready follows the setup cycle, so every read is a flop output
   wire setup = psel & ~penable;
   wire access = psel & penable & pready_q;
   wire wr = access & pwrite;
   wire rd = access & ~pwrite;

   wire [1:0] hit_st;
   wire [1:0] hit_cmd;
   wire [1:0] hit_rxq;
   wire [1:0] hit_txq;
   for (genvar c = 0; c < 2; c++) begin : g_dec
      assign hit_st[c] = paddr == chan_ofs(1'(c), STATUS_OFS);
      assign hit_cmd[c] = paddr == chan_ofs(1'(c), COMMAND_OFS);
      assign hit_rxq[c] = paddr == chan_ofs(1'(c), RX_QUEUE_OFS);
      assign hit_txq[c] = paddr == chan_ofs(1'(c), TX_QUEUE_OFS);
   end
   wire hit_opsel = paddr == OPSEL_OFS;
   wire hit_latch = paddr == LATCH_OFS;
   wire hit_mode = paddr == MODE_OFS;
   wire mapped = (|hit_st) | (|hit_cmd) | (|hit_rxq) | (|hit_txq) |
      hit_opsel | hit_latch | hit_mode;

   wire [7:0] rd_byte =
      hit_st[0] ? status_byte(ch_q[0]) :
      hit_st[1] ? status_byte(ch_q[1]) :
      hit_opsel ? opsel_q :
      hit_latch ? latch_q :
      hit_mode ? {4'h0, mode_q} : 8'h00;

   wire [1:0] cmd_wr = {2{wr}} & hit_cmd;
   wire [1:0] txq_wr = {2{wr}} & hit_txq;
   wire [1:0] txq_ok = txq_wr & {ch_q[1].trdy, ch_q[0].trdy};
   wire [1:0] rxq_rd = {2{rd}} & hit_rxq;
   wire [3:0] cmd_hi = pwdata[7:4];

   // ------------------------------------------------------------
   // Channel status next state
   // ------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         logic par_on;
         logic mdrop;
         logic take;
         logic put;
         logic load;
         logic shift;
         logic [3:0] tcnt;
         par_on = mode_q[2 * c + MODE_PAR];
         mdrop = mode_q[2 * c + MODE_MDROP];
         take = 1'b0;
         put = 1'b0;
         load = 1'b0;
         shift = 1'b0;
         tcnt = '0;
         ch_d[c] = ch_q[c];

         // Clears from software go first so a same-cycle event wins
         // same decode
         if (cmd_wr[c]) begin
            if (pwdata[CMD_RX_DIS]) begin
               ch_d[c].rx_en = 1'b0;
            end
            if (pwdata[CMD_RX_EN]) begin
               ch_d[c].rx_en = 1'b1;
            end
            if (pwdata[CMD_TX_DIS] && ch_q[c].tx_st != TX_OFF) begin
               if (ch_q[c].tx_cnt == '0 && ch_q[c].emt) begin
                  ch_d[c].tx_st = TX_OFF;
                  ch_d[c].emt = 1'b0;
               end else begin
                  ch_d[c].tx_st = TX_DRAIN;
               end
               ch_d[c].trdy = 1'b0;
            end
            if (pwdata[CMD_TX_EN] && ch_q[c].tx_st != TX_ON) begin
               ch_d[c].tx_st = TX_ON;
               ch_d[c].trdy = ch_q[c].tx_cnt < QUEUE_DEPTH;
               if (ch_q[c].tx_st == TX_OFF && ch_q[c].tx_cnt == '0) begin
                  ch_d[c].emt = 1'b1;
               end
            end
            if (cmd_hi == CMD_RST_RX) begin
               ch_d[c].rx_en = 1'b0;
               ch_d[c].rx_cnt = '0;
               ch_d[c].waiting = 1'b0;
               ch_d[c].brk_blk = 1'b0;
               ch_d[c].brk = 1'b0;
               ch_d[c].fe = 1'b0;
               ch_d[c].pe = 1'b0;
               ch_d[c].oe = 1'b0;
               ch_d[c].full = 1'b0;
               ch_d[c].rrdy = 1'b0;
            end
            if (cmd_hi == CMD_RST_TX) begin
               ch_d[c].tx_st = TX_OFF;
               ch_d[c].tx_cnt = '0;
               ch_d[c].emt = 1'b0;
               ch_d[c].trdy = 1'b0;
            end
            if (cmd_hi == CMD_RST_ERR) begin
               ch_d[c].oe = 1'b0;
               ch_d[c].brk = 1'b0;
               ch_d[c].pe = 1'b0;
               ch_d[c].fe = 1'b0;
            end
            if (cmd_hi == CMD_RST_BRKCHG) begin
               ch_d[c].chg = 1'b0;
            end
         end

         // Transmit queue bookkeeping
         // loads while not ready are dropped
         load = txq_wr[c] && ch_q[c].trdy;
         shift = tx_evt[c].to_shift && ch_q[c].tx_cnt != '0;
         tcnt = 4'(ch_d[c].tx_cnt + {3'b0, load} - {3'b0, shift});
         ch_d[c].tx_cnt = tcnt;
         if (load) begin
            ch_d[c].emt = 1'b0;
            if (tcnt == QUEUE_DEPTH) begin
               ch_d[c].trdy = 1'b0;
            end
         end
         if (shift && ch_d[c].tx_st == TX_ON) begin
            ch_d[c].trdy = 1'b1;
         end
         if (tx_evt[c].last_stop && tcnt == '0) begin
            if (ch_d[c].tx_st == TX_DRAIN) begin
               ch_d[c].tx_st = TX_OFF;
               ch_d[c].emt = 1'b0;
               ch_d[c].trdy = 1'b0;
            end else if (ch_d[c].tx_st == TX_ON) begin
               ch_d[c].emt = 1'b1;
            end
         end

         // Receive side: reads pop first, then the waiting char moves in
         if (rxq_rd[c] && ch_q[c].rx_cnt != '0) begin
            if (ch_q[c].waiting) begin
               ch_d[c].waiting = 1'b0;
               ch_d[c].brk = ch_d[c].brk | ch_q[c].w_brk;
               ch_d[c].fe = ch_d[c].fe | ch_q[c].w_fe;
               ch_d[c].pe = ch_d[c].pe | ch_q[c].w_pe;
            end else begin
               ch_d[c].rx_cnt = 4'(ch_q[c].rx_cnt - 4'd1);
               ch_d[c].full = 1'b0;
               if (ch_q[c].rx_cnt == 4'd1) begin
                  ch_d[c].rrdy = 1'b0;
               end
            end
         end

         // break seen only as a whole zero character
         take = rx_evt[c].done && !ch_q[c].brk_blk &&
            (ch_q[c].rx_en || mdrop);
         if (rx_evt[c].brk_end && ch_q[c].brk_blk) begin
            ch_d[c].brk_blk = 1'b0;
            ch_d[c].chg = 1'b1;
         end
         if (take && rx_evt[c].brk) begin
            ch_d[c].brk_blk = 1'b1;
            ch_d[c].chg = 1'b1;
         end
         if (take) begin
            put = ch_d[c].rx_cnt < QUEUE_DEPTH && !ch_d[c].waiting;
            if (put) begin
               ch_d[c].rx_cnt = 4'(ch_d[c].rx_cnt + 4'd1);
               ch_d[c].rrdy = 1'b1;
               if (ch_d[c].rx_cnt == QUEUE_DEPTH) begin
                  ch_d[c].full = 1'b1;
               end
               ch_d[c].brk = ch_d[c].brk | rx_evt[c].brk;
               ch_d[c].fe = ch_d[c].fe | rx_evt[c].ferr;
               ch_d[c].pe = mdrop ? rx_evt[c].adflag :
                  ch_d[c].pe | (par_on & rx_evt[c].perr);
            end else begin
               if (ch_d[c].waiting) begin
                  ch_d[c].oe = 1'b1;
               end
               ch_d[c].waiting = 1'b1;
               ch_d[c].w_brk = rx_evt[c].brk;
               ch_d[c].w_fe = rx_evt[c].ferr;
               ch_d[c].w_pe = mdrop ? rx_evt[c].adflag :
                  par_on & rx_evt[c].perr;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Output pin selection
   // ------------------------------------------------------------
   // Bits 7..4 follow interrupt sources 4, 0, 5, 1, never masked
   // pins 7..4
   wire [7:4] irq_src = {interrupt_status[4], interrupt_status[0],
      interrupt_status[5], interrupt_status[1]};
   wire [7:4] hi_od = opsel_q[7:4];
   wire [7:4] hi_lvl = (hi_od & ~irq_src) | (~hi_od & ~latch_q[7:4]);
   wire p3_od = opsel_q[3:2] == SEL_TIMER;
   wire p3_lvl = opsel_q[3:2] == SEL_LATCH ? ~latch_q[3] :
      opsel_q[3:2] == SEL_TIMER ? pin_src.ct_out :
      opsel_q[3:2] == SEL_TX1 ? pin_src.txb_1x : pin_src.rxb_1x;
   wire p2_lvl = opsel_q[1:0] == SEL_LATCH ? ~latch_q[2] :
      opsel_q[1:0] == SEL_TX16 ? pin_src.txa_16x :
      opsel_q[1:0] == SEL_TX1 ? pin_src.txa_1x : pin_src.rxa_1x;
   // Open-drain pins only ever pull low; enable is the inverse level
   wire [7:2] od = {hi_od, p3_od, 1'b0};
   wire [7:2] lvl = {hi_lvl, p3_lvl, p2_lvl};
   wire [7:2] op_out_d = lvl & ~od;
   wire [7:2] op_oe_d = ~od | ~lvl;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_q <= {CHAN_RST, CHAN_RST};
      end else begin
         ch_q <= ch_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q <= setup && !pwrite ? {24'h0, rd_byte} : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opsel_q <= OPSEL_RST;
         latch_q <= LATCH_RST;
         mode_q <= MODE_RST;
         pd_q <= 1'b0;
      end else begin
         if (wr && hit_opsel) begin
            opsel_q <= pwdata[7:0];
         end
         if (wr && hit_latch) begin
            latch_q <= pwdata[7:0];
         end
         if (wr && hit_mode) begin
            mode_q <= pwdata[3:0];
         end
         if (cmd_wr[0] && cmd_hi == CMD_PD_ON) begin
            pd_q <= 1'b1;
         end else if (cmd_wr[0] && cmd_hi == CMD_PD_OFF) begin
            pd_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_load_q <= '0;
         tx_data_q <= '0;
         rx_pop_q <= '0;
         op_out_q <= '0;
         op_oe_q <= '0;
      end else begin
         tx_load_q <= txq_ok;
         // Dropped loads must not disturb the byte handed to the shifter
         tx_data_q <= |txq_ok ? pwdata[7:0] : tx_data_q;
         rx_pop_q <= {rxq_rd[1] & (ch_q[1].rx_cnt != '0),
            rxq_rd[0] & (ch_q[0].rx_cnt != '0)};
         op_out_q <= op_out_d;
         op_oe_q <= op_oe_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_load = tx_load_q;
   assign tx_data = tx_data_q;
   assign rx_pop = rx_pop_q;
   assign tx_active = {ch_q[1].tx_st != TX_OFF, ch_q[0].tx_st != TX_OFF};
   assign rx_active = {ch_q[1].rx_en, ch_q[0].rx_en};
   assign break_change = {ch_q[1].chg, ch_q[0].chg};
   assign power_down = pd_q;
   assign op_out = op_out_q;
   assign op_oe = op_oe_q;
endmodule : duart_status
`default_nettype wire

// *** logic/duart_status_pkg.sv ***
package duart_status_pkg;
   // APB register map, byte addresses; channel B sits one stride above A
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] COMMAND_OFS = 8'h04;
   localparam logic [7:0] RX_QUEUE_OFS = 8'h08;
   localparam logic [7:0] TX_QUEUE_OFS = 8'h0c;
   localparam logic [7:0] CHAN_STRIDE = 8'h10;
   localparam logic [7:0] OPSEL_OFS = 8'h20;
   localparam logic [7:0] LATCH_OFS = 8'h24;
   localparam logic [7:0] MODE_OFS = 8'h28;
   // Reset values
   localparam logic [7:0] OPSEL_RST = 8'h00;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [3:0] MODE_RST = 4'h0;
   // Mode register: per channel, bit 2c parity on, bit 2c+1 multidrop
   localparam int MODE_PAR = 0;
   localparam int MODE_MDROP = 1;
   // Queue depth
   localparam logic [3:0] QUEUE_DEPTH = 4'd8;
   // Command fields
   localparam int CMD_RX_EN = 0;
   localparam int CMD_RX_DIS = 1;
   localparam int CMD_TX_EN = 2;
   localparam int CMD_TX_DIS = 3;
   localparam logic [3:0] CMD_RST_RX = 4'h2;
   localparam logic [3:0] CMD_RST_TX = 4'h3;
   localparam logic [3:0] CMD_RST_ERR = 4'h4;
   localparam logic [3:0] CMD_RST_BRKCHG = 4'h5;
   localparam logic [3:0] CMD_PD_ON = 4'he;
   localparam logic [3:0] CMD_PD_OFF = 4'hf;
   // Status bit positions
   localparam int ST_BRK = 7;
   localparam int ST_FE = 6;
   localparam int ST_PE = 5;
   localparam int ST_OE = 4;
   localparam int ST_EMT = 3;
   localparam int ST_TRDY = 2;
   localparam int ST_FULL = 1;
   localparam int ST_RRDY = 0;
   // Pin 3 and pin 2 select codes
   localparam logic [1:0] SEL_LATCH = 2'b00;
   localparam logic [1:0] SEL_TIMER = 2'b01;
   localparam logic [1:0] SEL_TX16 = 2'b01;
   localparam logic [1:0] SEL_TX1 = 2'b10;
   localparam logic [1:0] SEL_RX1 = 2'b11;

   typedef enum logic [1:0] {
      TX_OFF = 2'b00,
      TX_ON = 2'b01,
      TX_DRAIN = 2'b11
   } tx_state_t;

   // Per character report from the receive shifter
   typedef struct packed {
      logic done;
      logic brk;
      logic ferr;
      logic perr;
      logic adflag;
      logic brk_end;
   } rx_evt_t;

   // Per character report from the transmit shifter
   typedef struct packed {
      logic to_shift;
      logic last_stop;
   } tx_evt_t;

   // Clocks and timer level that can be routed to the output pins
   typedef struct packed {
      logic ct_out;
      logic txa_16x;
      logic txa_1x;
      logic rxa_1x;
      logic txb_1x;
      logic rxb_1x;
   } pin_src_t;

   typedef struct packed {
      tx_state_t tx_st;
      logic [3:0] tx_cnt;
      logic emt;
      logic trdy;
      logic rx_en;
      logic [3:0] rx_cnt;
      logic waiting;
      logic brk_blk;
      logic brk;
      logic fe;
      logic pe;
      logic oe;
      logic full;
      logic rrdy;
      logic chg;
      logic w_brk;
      logic w_fe;
      logic w_pe;
   } chan_t;

   localparam chan_t CHAN_RST = '{tx_st: TX_OFF, default: '0};
endpackage : duart_status_pkg

// *** tb/duart_status_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module duart_status_asserts
   import duart_status_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire rx_evt_t [1:0] rx_evt,
   input wire logic [7:0] interrupt_status,
   input wire pin_src_t pin_src,
   input wire logic [1:0] tx_load,
   input wire logic [1:0] rx_pop,
   input wire logic [1:0] break_change,
   input wire logic power_down,
   input wire logic [7:2] op_out,
   input wire logic [7:2] op_oe
);
   // ----------------------------------------
   // Decoded bus and event causes
   // ----------------------------------------
   logic live_q;
   wire acc = psel && penable && pready;
   wire wr_cmd_a = acc && pwrite && paddr == COMMAND_OFS;
   wire pd_cmd = wr_cmd_a && pwdata[7:5] == 3'b111;
   wire wr_txq_a = acc && pwrite && paddr == TX_QUEUE_OFS;
   wire rd_rxq_a = acc && !pwrite && paddr == RX_QUEUE_OFS;
   wire brk_a = rx_evt[0].brk || rx_evt[0].brk_end;
   wire brk_b = rx_evt[1].brk || rx_evt[1].brk_end;
   wire ct = pin_src.ct_out;
   wire [3:0] isr_map = {interrupt_status[4], interrupt_status[0],
      interrupt_status[5], interrupt_status[1]};
   // Pins hold reset levels for one edge after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_q <= 1'b0;
      end else begin
         live_q <= 1'b1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ans;
      psel && !penable |=> pready && penable;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_stat_ro;
      acc && paddr == STATUS_OFS |-> !pslverr;
   endproperty
   a_stat_ro: assert property (p_stat_ro) else $error("status err");
   property p_pop;
      rx_pop[0] |-> $past(rd_rxq_a) || $past(rd_rxq_a, 2);
   endproperty
   a_pop: assert property (p_pop) else $error("stray pop");
   property p_load;
      tx_load[0] |-> $past(wr_txq_a) || $past(wr_txq_a, 2);
   endproperty
   a_load: assert property (p_load) else $error("stray load");
   property p_brk_a;
      $rose(break_change[0]) |-> $past(brk_a);
   endproperty
   a_brk_a: assert property (p_brk_a) else $error("chg a");
   property p_brk_b;
      $rose(break_change[1]) |-> $past(brk_b);
   endproperty
   a_brk_b: assert property (p_brk_b) else $error("chg b");
   property p_brk_clr;
      $fell(break_change[0]) |-> $past(wr_cmd_a);
   endproperty
   a_brk_clr: assert property (p_brk_clr) else $error("chg clr");
   property p_pd;
      $changed(power_down) |-> $past(pd_cmd);
   endproperty
   a_pd: assert property (p_pd) else $error("power down");
   property p_odr;
      live_q |-> ((~op_oe[7:4]) & $past(isr_map)) == 4'h0;
   endproperty
   a_odr: assert property (p_odr) else $error("pin released");
   property p_ct;
      live_q && !op_oe[3] |-> $past(ct) && !op_out[3];
   endproperty
   a_ct: assert property (p_ct) else $error("pin 3");
   property p_pin2;
      live_q |-> op_oe[2];
   endproperty
   a_pin2: assert property (p_pin2) else $error("pin 2");
endmodule : duart_status_asserts
bind duart_status duart_status_asserts duart_status_asserts_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .rx_evt(rx_evt), .pin_src(pin_src),
   .interrupt_status(interrupt_status), .tx_load(tx_load),
   .rx_pop(rx_pop), .break_change(break_change),
   .power_down(power_down), .op_out(op_out), .op_oe(op_oe)
);
`default_nettype wire

// *** tb/serial_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_far_end
   import duart_status_pkg::*;
(
   input wire logic pclk,
   output rx_evt_t [1:0] rx_evt,
   output tx_evt_t [1:0] tx_evt,
   output pin_src_t pin_src
);
   logic [4:0] cnt_q = 5'h00;
   initial begin
      rx_evt = '0;
      tx_evt = '0;
   end
   // clocks run free, even between characters
   always @(posedge pclk) begin
      cnt_q <= cnt_q + 5'h01;
   end
   assign pin_src = {cnt_q[4], cnt_q[0], cnt_q[2], cnt_q[3], cnt_q[1],
      cnt_q[3] ^ cnt_q[2]};
   // line events come as whole characters, one per call
   task ev(input int c, input rx_evt_t r, input tx_evt_t t);
      @(posedge pclk);
      rx_evt[c] <= r;
      tx_evt[c] <= t;
      @(posedge pclk);
      rx_evt[c] <= '0;
      tx_evt[c] <= '0;
      @(negedge pclk);
   endtask : ev
endmodule : serial_far_end
`default_nettype wire

// *** tb/duart_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module duart_status_tb
   import duart_status_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
   logic power_down, e2;
   logic [1:0] e3, tx_load, rx_pop, tx_active, rx_active, break_change;
   logic [7:0] paddr, interrupt_status, rd_q, tx_data;
   logic [31:0] pwdata, prdata;
   logic [7:2] op_out, op_oe;
   rx_evt_t [1:0] rx_evt;
   tx_evt_t [1:0] tx_evt;
   pin_src_t pin_src, src_q;
   int n_fail, check_count;
   localparam logic [7:0] SB = STATUS_OFS + CHAN_STRIDE;
   localparam logic [7:0] CB = COMMAND_OFS + CHAN_STRIDE;
   localparam rx_evt_t CH = 6'h20;
   localparam rx_evt_t BRK = 6'h30;
   localparam rx_evt_t FE = 6'h28;
   localparam rx_evt_t PE = 6'h24;
   localparam rx_evt_t AD = 6'h22;
   localparam rx_evt_t BEND = 6'h01;
   duart_status duart_status_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_evt(rx_evt), .tx_evt(tx_evt),
      .interrupt_status(interrupt_status), .pin_src(pin_src),
      .tx_load(tx_load), .tx_data(tx_data), .rx_pop(rx_pop),
      .tx_active(tx_active), .rx_active(rx_active),
      .break_change(break_change), .power_down(power_down),
      .op_out(op_out), .op_oe(op_oe));
   serial_far_end serial_far_end_i (.pclk(pclk), .rx_evt(rx_evt),
      .tx_evt(tx_evt), .pin_src(pin_src));
   // Pin outputs are one flop behind their sources
   always @(posedge pclk) begin
      src_q <= pin_src;
   end
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ----------------------------------------
   // Bus and checking tasks
   // ----------------------------------------
   task check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_q = prdata[7:0];
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) n_fail++;
      @(negedge pclk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(rd_q, exp);
   endtask : rc
   task fin(input string s);
      $display("test %s done", s);
   endtask : fin
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      give_verdict;
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      interrupt_status = 8'h00;
      n_fail = 0;
      check_count = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rc(STATUS_OFS, 8'h00);
      rc(SB, 8'h00);
      rc(OPSEL_OFS, OPSEL_RST);
      apb(1'b0, 8'h30, 8'h00);
      check({7'h0, err_q}, 8'h01);
      fin("reset");
      wr(COMMAND_OFS, 8'h04);
      check({6'h0, tx_active}, 8'h01);
      rc(STATUS_OFS, 8'h0c);
      // Ninth load must be dropped while the queue is full
      for (int i = 0; i < 9; i++) begin
         wr(TX_QUEUE_OFS, i[7:0]);
         if (i == 6) rc(STATUS_OFS, 8'h04);
      end
      check({6'h0, tx_load}, 8'h00);
      rc(STATUS_OFS, 8'h00);
      check(tx_data, 8'h07);
      serial_far_end_i.ev(0, '0, 2'b10);
      rc(STATUS_OFS, 8'h04);
      repeat (7) serial_far_end_i.ev(0, '0, 2'b10);
      serial_far_end_i.ev(0, '0, 2'b01);
      rc(STATUS_OFS, 8'h0c);
      wr(COMMAND_OFS, 8'h08);
      check({6'h0, tx_active}, 8'h00);
      rc(STATUS_OFS, 8'h00);
      wr(STATUS_OFS, 8'hff);
      rc(STATUS_OFS, 8'h00);
      fin("tx");
      wr(MODE_OFS, 8'h09);
      wr(COMMAND_OFS, 8'h01);
      serial_far_end_i.ev(0, PE, '0);
      rc(STATUS_OFS, 8'h21);
      repeat (7) serial_far_end_i.ev(0, CH, '0);
      rc(STATUS_OFS, 8'h23);
      serial_far_end_i.ev(0, FE, '0);
      rc(STATUS_OFS, 8'h23);
      // The waiting framing error is lost with its character
      serial_far_end_i.ev(0, CH, '0);
      rc(STATUS_OFS, 8'h33);
      apb(1'b0, RX_QUEUE_OFS, 8'h00);
      rc(STATUS_OFS, 8'h33);
      wr(COMMAND_OFS, 8'h40);
      rc(STATUS_OFS, 8'h03);
      apb(1'b0, RX_QUEUE_OFS, 8'h00);
      rc(STATUS_OFS, 8'h01);
      repeat (6) apb(1'b0, RX_QUEUE_OFS, 8'h00);
      rc(STATUS_OFS, 8'h01);
      apb(1'b0, RX_QUEUE_OFS, 8'h00);
      rc(STATUS_OFS, 8'h00);
      fin("rx");
      serial_far_end_i.ev(0, BRK, '0);
      check({7'h0, break_change[0]}, 8'h01);
      serial_far_end_i.ev(0, CH, '0);
      rc(STATUS_OFS, 8'h81);
      apb(1'b0, RX_QUEUE_OFS, 8'h00);
      check({6'h0, rx_pop}, 8'h01);
      rc(STATUS_OFS, 8'h80);
      wr(COMMAND_OFS, 8'h50);
      check({7'h0, break_change[0]}, 8'h00);
      serial_far_end_i.ev(0, BEND, '0);
      check({7'h0, break_change[0]}, 8'h01);
      serial_far_end_i.ev(0, FE, '0);
      rc(STATUS_OFS, 8'hc1);
      wr(COMMAND_OFS, 8'h20);
      check({6'h0, rx_active}, 8'h00);
      rc(STATUS_OFS, 8'h00);
      serial_far_end_i.ev(1, AD, '0);
      rc(SB, 8'h21);
      serial_far_end_i.ev(1, BRK, '0);
      check({7'h0, break_change[1]}, 8'h01);
      fin("break");
      wr(CB, 8'he0);
      check({7'h0, power_down}, 8'h00);
      wr(COMMAND_OFS, 8'he0);
      check({7'h0, power_down}, 8'h01);
      wr(COMMAND_OFS, 8'hf0);
      check({7'h0, power_down}, 8'h00);
      fin("command");
      wr(LATCH_OFS, 8'ha4);
      @(negedge pclk);
      check({op_out, op_oe[3:2]}, 8'h5b);
      @(posedge pclk);
      interrupt_status <= 8'h11;
      wr(OPSEL_OFS, 8'hf0);
      @(negedge pclk);
      check({op_out[7:4], op_oe[7:4]}, 8'h0c);
      rc(OPSEL_OFS, 8'hf0);
      for (int k = 1; k < 4; k++) begin
         wr(OPSEL_OFS, {4'h0, k[1:0], k[1:0]});
         repeat (6) begin
            @(negedge pclk);
            e3 = k == 1 ? {~src_q.ct_out, 1'b0} :
               {1'b1, k == 2 ? src_q.txb_1x : src_q.rxb_1x};
            e2 = k == 1 ? src_q.txa_16x :
               k == 2 ? src_q.txa_1x : src_q.rxa_1x;
            check({op_oe[3], op_out[3:2]}, {5'h0, e3, e2});
         end
      end
      fin("pins");
      give_verdict;
   end
endmodule : duart_status_tb
`default_nettype wire
